// File: include/can_bit_timing_map.svh
/*
  register offsets, field positions, reset values and timing figures
  for the can bit-timing configuration stage.
  assumes inclusion by bare name from files that need the layout.
*/
`ifndef CAN_BIT_TIMING_MAP_SVH
`define CAN_BIT_TIMING_MAP_SVH
`define CBT_ADDR_TIMING   8'h00
`define CBT_ADDR_CONTROL  8'h04
`define CBT_ADDR_STATUS   8'h08
`define CBT_TIMING_RESET  32'h0000_0000
`define CBT_TIMING_WMASK  32'h0047_ffff
`define CBT_WAKE_BIT      22
`define CBT_PH2_HI        18
`define CBT_PH2_LO        16
`define CBT_PH2SEL_BIT    15
`define CBT_TRIPLE_BIT    14
`define CBT_PH1_HI        13
`define CBT_PH1_LO        11
`define CBT_PROP_HI       10
`define CBT_PROP_LO       8
`define CBT_SJW_HI        7
`define CBT_SJW_LO        6
`define CBT_BRP_HI        5
`define CBT_BRP_LO        0
`define CBT_MODE_HI       2
`define CBT_MODE_LO       0
`define CBT_MODE_CONFIG   3'h4
`define CBT_MODE_RESET    3'h4
`define CBT_IPT_QUANTA    3'h1
`define CBT_FILT_LEN      4
`endif

// File: include/can_bit_timing_pkg.sv
/*
  types for the can bit-timing configuration stage.
  assumes the map header supplies all numeric layout.
*/
package can_bit_timing_pkg;
  typedef enum logic [1:0] {
    ST_SYNC,
    ST_PROP,
    ST_PH1,
    ST_PH2
  } seg_state_t;
endpackage

// File: hw/can_line_filter.sv
/*
  glitch filter for the receive line: output follows the input only
  after it has held one level for len consecutive clocks.
  assumes rx is already synchronous to the clock.
*/
`timescale 1ns/10ps
`default_nettype none
module can_line_filter #(
  parameter int LEN = 4
) (
  // clock and reset
  input  wire logic ref_clk_in,
  input  wire logic rstn_in,
  // line
  input  wire logic line_in,
  output var  logic line_out
);
  localparam int CW = $clog2(LEN + 1);
  logic [CW-1:0] cnt_reg;
  logic [CW-1:0] cnt_next;
  logic          lvl_reg;
  logic          lvl_next;

  always_comb begin
    cnt_next = cnt_reg;
    lvl_next = lvl_reg;
    if (line_in == lvl_reg) begin
      cnt_next = '0;
    end else if (cnt_reg == CW'(LEN - 1)) begin
      cnt_next = '0;
      lvl_next = line_in;
    end else begin
      cnt_next = cnt_reg + 1'b1;
    end
  end

  always_ff @(posedge ref_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      cnt_reg <= '0;
      lvl_reg <= 1'b1;
    end else begin
      cnt_reg <= cnt_next;
      lvl_reg <= lvl_next;
    end
  end

  assign line_out = lvl_reg;
endmodule
`default_nettype wire

// File: hw/can_bit_timing_config.sv
/*
  bit-timing register, quantum prescaler, nominal bit segment
  sequencer, sample point voting and wake-up detection.
  assumes rx is synchronous to ref_clk_in and software honours the
  programming limits; operating mode comes from a control register.
*/
`timescale 1ns/10ps
`default_nettype none
`include "can_bit_timing_map.svh"
module can_bit_timing_config #(
  parameter int FILT_LEN = `CBT_FILT_LEN
) (
  // clock and reset
  input  wire logic        ref_clk_in,
  input  wire logic        rstn_in,
  // register port
  input  wire logic [7:0]  addr_in,
  input  wire logic [31:0] wdata_in,
  input  wire logic        wr_in,
  input  wire logic        rd_in,
  output var  logic [31:0] rdata_out,
  // can receive line
  input  wire logic        rx_in,
  // timing results
  output var  logic        tq_tick_out,
  output var  logic        sample_point_out,
  output var  logic        sample_bit_out,
  output var  logic        bit_start_out,
  output var  logic        wake_out
);
  logic [31:0] timing_reg, timing_next;
  logic [2:0]  mode_reg, mode_next;
  logic [31:0] rdata_reg, rdata_next;
  logic [5:0]  pre_reg, pre_next;
  logic [2:0]  qcnt_reg, qcnt_next;
  can_bit_timing_pkg::seg_state_t st_reg, st_next;
  logic [1:0]  smp_reg, smp_next;
  logic        tq_reg, sp_reg, sb_reg, bs_reg, wake_reg, rx_d_reg;
  logic        tq_next, sp_next, sb_next, bs_next, wake_next;
  logic        rx_filt, wake_src;
  logic [2:0]  ph1_f, ph2_f, prop_f, ph2_auto, ph2_eff;
  logic [5:0]  brp_f;
  logic        cfg_mode, vote;

  assign ph1_f  = timing_reg[`CBT_PH1_HI:`CBT_PH1_LO];
  assign ph2_f  = timing_reg[`CBT_PH2_HI:`CBT_PH2_LO];
  assign prop_f = timing_reg[`CBT_PROP_HI:`CBT_PROP_LO];
  assign brp_f  = timing_reg[`CBT_BRP_HI:`CBT_BRP_LO];
  assign cfg_mode = (mode_reg == `CBT_MODE_CONFIG);
  // derived length: greater of phase one and processing time
  assign ph2_auto = (ph1_f > `CBT_IPT_QUANTA) ? ph1_f
                                              : `CBT_IPT_QUANTA;
  assign ph2_eff = timing_reg[`CBT_PH2SEL_BIT] ? ph2_f : ph2_auto;

  can_line_filter #(.LEN(FILT_LEN)) u_filt (
    .ref_clk_in (ref_clk_in),
    .rstn_in    (rstn_in),
    .line_in    (rx_in),
    .line_out   (rx_filt)
  );
  assign wake_src = timing_reg[`CBT_WAKE_BIT] ? rx_filt : rx_in;

  // register file
  always_comb begin
    timing_next = timing_reg;
    mode_next   = mode_reg;
    rdata_next  = '0;
    if (wr_in && addr_in == `CBT_ADDR_TIMING && cfg_mode) begin
      timing_next = wdata_in & `CBT_TIMING_WMASK;
    end else if (wr_in && addr_in == `CBT_ADDR_CONTROL) begin
      mode_next = wdata_in[`CBT_MODE_HI:`CBT_MODE_LO];
    end
    // field mirrors derived length when select is clear
    if (!timing_next[`CBT_PH2SEL_BIT]) begin
      timing_next[`CBT_PH2_HI:`CBT_PH2_LO] =
        (timing_next[`CBT_PH1_HI:`CBT_PH1_LO] > `CBT_IPT_QUANTA) ?
        timing_next[`CBT_PH1_HI:`CBT_PH1_LO] : `CBT_IPT_QUANTA;
    end
    if (rd_in) begin
      if (addr_in == `CBT_ADDR_TIMING) begin
        rdata_next = timing_reg;
      end else if (addr_in == `CBT_ADDR_CONTROL) begin
        rdata_next = {29'h0000_0000, mode_reg};
      end else if (addr_in == `CBT_ADDR_STATUS) begin
        rdata_next = {28'h000_0000, wake_reg, rx_filt,
                      cfg_mode, sb_reg};
      end else begin
        rdata_next = '0;
      end
    end
  end

  // quantum prescaler and segment sequencer
  always_comb begin
    pre_next  = pre_reg;
    qcnt_next = qcnt_reg;
    st_next   = st_reg;
    smp_next  = smp_reg;
    tq_next   = 1'b0;
    sp_next   = 1'b0;
    bs_next   = 1'b0;
    sb_next   = sb_reg;
    vote      = 1'b0;
    if (cfg_mode) begin
      // sequencer held while timing may change
      pre_next  = '0;
      qcnt_next = '0;
      st_next   = can_bit_timing_pkg::ST_SYNC;
    end else if (pre_reg == brp_f) begin
      pre_next = '0;
      tq_next  = 1'b1; // quantum is brp+1 clocks
    end else begin
      pre_next = pre_reg + 1'b1;
    end
    // samples one quantum apart ending at the sample point; a tick
    // left over on entry to configuration must not move the sequencer
    if (tq_reg && !cfg_mode) begin
      smp_next = {smp_reg[0], rx_in};
      case (st_reg)
        can_bit_timing_pkg::ST_SYNC: begin
          st_next   = can_bit_timing_pkg::ST_PROP;
          qcnt_next = '0;
        end
        can_bit_timing_pkg::ST_PROP: begin
          if (qcnt_reg == prop_f) begin
            st_next   = can_bit_timing_pkg::ST_PH1;
            qcnt_next = '0;
          end else begin
            qcnt_next = qcnt_reg + 1'b1;
          end
        end
        can_bit_timing_pkg::ST_PH1: begin
          if (qcnt_reg == ph1_f) begin
            st_next   = can_bit_timing_pkg::ST_PH2;
            qcnt_next = '0;
            sp_next   = 1'b1;
            vote = (smp_reg[1] & smp_reg[0]) | (smp_reg[1] & rx_in)
                 | (smp_reg[0] & rx_in);
            sb_next = timing_reg[`CBT_TRIPLE_BIT] ? vote : rx_in;
          end else begin
            qcnt_next = qcnt_reg + 1'b1;
          end
        end
        default: begin
          if (qcnt_reg == ph2_eff) begin
            st_next   = can_bit_timing_pkg::ST_SYNC;
            qcnt_next = '0;
            bs_next   = 1'b1;
          end else begin
            qcnt_next = qcnt_reg + 1'b1;
          end
        end
      endcase
    end
    // wake on a falling edge of the chosen line
    wake_next = rx_d_reg & ~wake_src;
  end

  always_ff @(posedge ref_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      timing_reg <= `CBT_TIMING_RESET;
      mode_reg   <= `CBT_MODE_RESET;
      rdata_reg  <= '0;
      pre_reg    <= '0;
      qcnt_reg   <= '0;
      st_reg     <= can_bit_timing_pkg::ST_SYNC;
      smp_reg    <= 2'h3;
      tq_reg     <= 1'b0;
      sp_reg     <= 1'b0;
      sb_reg     <= 1'b1;
      bs_reg     <= 1'b0;
      wake_reg   <= 1'b0;
      rx_d_reg   <= 1'b1;
    end else begin
      timing_reg <= timing_next;
      mode_reg   <= mode_next;
      rdata_reg  <= rdata_next;
      pre_reg    <= pre_next;
      qcnt_reg   <= qcnt_next;
      st_reg     <= st_next;
      smp_reg    <= smp_next;
      tq_reg     <= tq_next;
      sp_reg     <= sp_next;
      sb_reg     <= sb_next;
      bs_reg     <= bs_next;
      wake_reg   <= wake_next;
      rx_d_reg   <= wake_src;
    end
  end

  assign rdata_out        = rdata_reg;
  assign tq_tick_out      = tq_reg;
  assign sample_point_out = sp_reg;
  assign sample_bit_out   = sb_reg;
  assign bit_start_out    = bs_reg;
  assign wake_out         = wake_reg;

  // checks
  AST_NO_WRITE_OUTSIDE_CFG: assert property (
    @(posedge ref_clk_in) disable iff (!rstn_in)
    !cfg_mode |=> timing_reg == $past(timing_reg))
    else $error("timing register changed outside configuration mode");
  AST_WRITE_IN_CFG: assert property (
    @(posedge ref_clk_in) disable iff (!rstn_in)
    (wr_in && addr_in == `CBT_ADDR_TIMING && cfg_mode
     && wdata_in[`CBT_PH2SEL_BIT])
    |=> timing_reg == ($past(wdata_in) & `CBT_TIMING_WMASK))
    else $error("timing write in configuration mode lost");
  // field is reloaded one edge after reset releases
  AST_AUTO_PH2: assert property (
    @(posedge ref_clk_in) disable iff (!rstn_in)
    (!timing_reg[`CBT_PH2SEL_BIT] && $past(rstn_in))
    |-> ph2_f == ph2_auto)
    else $error("phase two field not loaded automatically");
  AST_PH2_EFF: assert property (
    @(posedge ref_clk_in) disable iff (!rstn_in)
    (timing_reg[`CBT_PH2SEL_BIT] ? ph2_eff == ph2_f
     : (ph2_eff >= ph1_f && ph2_eff >= `CBT_IPT_QUANTA
        && (ph2_eff == ph1_f || ph2_eff == `CBT_IPT_QUANTA))))
    else $error("wrong phase two length selected");
  AST_SP_AFTER_PH1: assert property (
    @(posedge ref_clk_in) disable iff (!rstn_in)
    sp_reg |-> $past(st_reg) == can_bit_timing_pkg::ST_PH1
            && $past(qcnt_reg) == ph1_f)
    else $error("sample point not at end of phase one");
  AST_BIT_END_PH2: assert property (
    @(posedge ref_clk_in) disable iff (!rstn_in)
    bs_reg |-> $past(st_reg) == can_bit_timing_pkg::ST_PH2
            && $past(qcnt_reg) == ph2_eff)
    else $error("bit not ended after phase two");
  AST_SYNC_ONE_TQ: assert property (
    @(posedge ref_clk_in) disable iff (!rstn_in)
    (tq_reg && st_reg == can_bit_timing_pkg::ST_SYNC && !cfg_mode)
    |=> st_reg == can_bit_timing_pkg::ST_PROP)
    else $error("sync segment not one quantum");
  AST_SINGLE_SAMPLE: assert property (
    @(posedge ref_clk_in) disable iff (!rstn_in)
    (sp_reg && !timing_reg[`CBT_TRIPLE_BIT]) |-> sb_reg == $past(rx_in))
    else $error("single sample mismatch");
  // the edge detector compares the chosen line over the last two edges
  AST_WAKE_BYPASS: assert property (
    @(posedge ref_clk_in) disable iff (!rstn_in)
    (!$past(timing_reg[`CBT_WAKE_BIT])
     && !$past(timing_reg[`CBT_WAKE_BIT], 2)
     && $past(rx_in, 2) && !$past(rx_in)) |-> wake_reg)
    else $error("unfiltered wake edge missed");
  COV_TRIPLE: cover property (@(posedge ref_clk_in) disable iff (!rstn_in)
    sp_reg && timing_reg[`CBT_TRIPLE_BIT]);
  COV_BIT: cover property (@(posedge ref_clk_in) disable iff (!rstn_in)
    bs_reg);
  COV_WAKE_FILT: cover property (@(posedge ref_clk_in)
    disable iff (!rstn_in) wake_reg && timing_reg[`CBT_WAKE_BIT]);
endmodule
`default_nettype wire

// File: testbench/can_bus_node_model.sv
/*
  far-side model: the other nodes on the can bus, seen as one rx line.
  assumes the bench calls its tasks; idle bus is recessive (1).
*/
`timescale 1ns/10ps
`default_nettype none
module can_bus_node_model (
  // clock
  input  wire logic ref_clk_in,
  // bus line towards the node under test
  output var  logic rx_out
);
  initial rx_out = 1'b1;

  // level for some clocks, then the bus floats back to recessive
  task automatic drive(input logic level, input int clocks);
    @(posedge ref_clk_in);
    rx_out <= level;
    repeat (clocks) @(posedge ref_clk_in);
    rx_out <= 1'b1;
  endtask

  task automatic hold(input logic level);
    @(posedge ref_clk_in);
    rx_out <= level;
  endtask
endmodule
`default_nettype wire

// File: testbench/tb_can_bit_timing_config.sv
/*
  self-checking bench for the bit-timing stage: registers, segment
  lengths, sampling and wake-up.
  assumes the bus node model drives rx; one 100 MHz clock.
*/
`timescale 1ns/10ps
`default_nettype none
module tb_can_bit_timing_config;
  logic        ref_clk_in;
  logic        rstn_in;
  logic [7:0]  addr_in;
  logic [31:0] wdata_in;
  logic        wr_in;
  logic        rd_in;
  logic [31:0] rdata_out;
  logic        rx_in;
  logic        tq_tick_out;
  logic        sample_point_out;
  logic        sample_bit_out;
  logic        bit_start_out;
  logic        wake_out;
  int          num_errors;
  int          comparisons;
  int          cycles;

  can_bit_timing_config u_can_bit_timing_config (
    .ref_clk_in(ref_clk_in), .rstn_in(rstn_in), .addr_in(addr_in),
    .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in),
    .rdata_out(rdata_out), .rx_in(rx_in), .tq_tick_out(tq_tick_out),
    .sample_point_out(sample_point_out),
    .sample_bit_out(sample_bit_out), .bit_start_out(bit_start_out),
    .wake_out(wake_out));

  can_bus_node_model u_can_bus_node_model (
    .ref_clk_in(ref_clk_in), .rx_out(rx_in));

  initial begin
    ref_clk_in = 1'b0;
    forever #5 ref_clk_in = ~ref_clk_in;
  end

  task automatic final_report;
    $display("comparisons=%0d num_errors=%0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  // hang guard, far above the fewer than a thousand cycles the tests need
  always @(posedge ref_clk_in) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      num_errors++;
      final_report();
    end
  end

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      num_errors++;
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk_in);
    addr_in <= a;
    wdata_in <= d;
    wr_in <= 1'b1;
    @(posedge ref_clk_in);
    wr_in <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    @(posedge ref_clk_in);
    addr_in <= a;
    rd_in <= 1'b1;
    @(posedge ref_clk_in);
    rd_in <= 1'b0;
    #1 check(rdata_out, exp);
  endtask

  // 0 quantum tick, 1 sample point, 2 bit start
  function automatic logic pick(input int w);
    case (w)
      0: return tq_tick_out;
      1: return sample_point_out;
      default: return bit_start_out;
    endcase
  endfunction

  // clocks from a pulse of one kind to the next pulse of the same or another kind
  task automatic gap(input int a, input int b, input int exp);
    int n;
    n = 0;
    do begin
      @(negedge ref_clk_in);
      n++;
    end while (pick(a) !== 1'b1 && n < 200);
    n = 0;
    do begin
      @(negedge ref_clk_in);
      n++;
    end while (pick(b) !== 1'b1 && n < 200);
    check(32'(n), 32'(exp));
  endtask

  // low pulse on the bus, wake pulses counted meanwhile
  task automatic wakes(input int lo, input int exp);
    int n;
    n = 0;
    fork
      u_can_bus_node_model.drive(1'b0, lo);
      repeat (lo + 16) begin
        @(negedge ref_clk_in);
        if (wake_out === 1'b1) n++;
      end
    join
    check(32'(n), 32'(exp));
  endtask

  // two-clock low pulse that covers only the next bit's sample point
  task automatic glitch(input int bitclk, input logic exp);
    int n;
    n = 0;
    do begin
      @(negedge ref_clk_in);
      n++;
    end while (sample_point_out !== 1'b1 && n < 200);
    repeat (bitclk - 2) @(posedge ref_clk_in);
    u_can_bus_node_model.drive(1'b0, 2);
    @(negedge ref_clk_in);
    check(32'(sample_bit_out), 32'(exp));
  endtask

  initial begin
    num_errors = 0;
    comparisons = 0;
    cycles = 0;
    rstn_in = 1'b0;
    addr_in = 8'h00;
    wdata_in = 32'h0000_0000;
    wr_in = 1'b0;
    rd_in = 1'b0;
    repeat (12) @(posedge ref_clk_in);
    rstn_in <= 1'b1;
    rd(8'h00, 32'h0001_0000);
    rd(8'h04, 32'h0000_0004);
    rd(8'h0c, 32'h0000_0000);
    rd(8'h08, 32'h0000_0007);
    wr(8'h00, 32'hffff_ffff);
    rd(8'h00, 32'h0047_ffff);
    $display("registers done");
    // brp 3, prop 1, ph1 3, ph2 2, jump 1: 10 quanta of 4 clocks
    wr(8'h00, 32'h0042_d943);
    rd(8'h00, 32'h0042_d943);
    wr(8'h04, 32'h0000_0000);
    wr(8'h00, 32'h0000_1943);
    rd(8'h00, 32'h0042_d943);
    gap(0, 0, 4);
    gap(2, 2, 40);
    gap(1, 2, 12);
    u_can_bus_node_model.hold(1'b0);
    gap(2, 2, 40);
    check(32'(sample_bit_out), 32'h0);
    u_can_bus_node_model.hold(1'b1);
    gap(2, 2, 40);
    check(32'(sample_bit_out), 32'h1);
    glitch(40, 1'b1);
    $display("programmed phase two done");
    wr(8'h04, 32'h0000_0004);
    wr(8'h00, 32'h0000_1943);
    rd(8'h00, 32'h0003_1943);
    wr(8'h04, 32'h0000_0000);
    gap(2, 2, 44);
    gap(1, 2, 16);
    u_can_bus_node_model.hold(1'b0);
    gap(2, 2, 44);
    check(32'(sample_bit_out), 32'h0);
    u_can_bus_node_model.hold(1'b1);
    glitch(44, 1'b0);
    $display("derived phase two done");
    wr(8'h04, 32'h0000_0004);
    wakes(2, 1);
    wr(8'h00, 32'h0040_1943);
    wakes(2, 0);
    wakes(10, 1);
    $display("wake filter done");
    final_report();
  end
endmodule
`default_nettype wire
